// file: hw/dbc_defs.vh
// Purpose: Constants for the driver and buck configuration register bank
// Assumes: Included by bare name; definitions only
// Notes:   Offsets are register indices; byte address is four times the index
`ifndef DBC_DEFS_VH
`define DBC_DEFS_VH

// ==========================================================================
// Register indices
// ==========================================================================
`define DBC_IDX_ALGO_ONE     8'hA0
`define DBC_IDX_ALGO_TWO     8'hA2
`define DBC_IDX_DRV_BUCK     8'hAE
`define DBC_IDX_STATUS       8'hB0

// ==========================================================================
// Reset values
// ==========================================================================
`define DBC_RST_ALGO_ONE     32'h00000000
`define DBC_RST_ALGO_TWO     32'h00000000
`define DBC_RST_DRV_BUCK     32'h01200000

// ==========================================================================
// Field positions in the driver and buck configuration word
// ==========================================================================
`define DBC_BIT_PARITY       31
`define DBC_BIT_COMP_EN      30
`define DBC_TDLY_HI          29
`define DBC_TDLY_LO          26
`define DBC_BIT_EDGE_RATE    25
`define DBC_BIT_SEQ_OFF      24
`define DBC_BIT_CUR_CAP      23
`define DBC_VSEL_HI          22
`define DBC_VSEL_LO          21
`define DBC_BIT_REG_OFF      20

// Slew rate field of the neighbouring gate driver word
`define DBC_SLEW_HI          27
`define DBC_SLEW_LO          26

// ==========================================================================
// Delay codes, in units of 0.2 us (code 1 is 0.4 us)
// ==========================================================================
`define DBC_DLY_BASE_STEPS   5'h01
`define DBC_AUTO_S0          5'h10
`define DBC_AUTO_S1          5'h0C
`define DBC_AUTO_S2          5'h06
`define DBC_AUTO_S3          5'h04

`endif

// file: hw/dbc_delay_sel.v
// Purpose: Resolve the effective target delay from the fixed code or slew rate
// Assumes: Inputs come from registers on the same clock
// Notes:   Output is a registered count of 0.2 us steps
`timescale 1ns/10ps
`include "dbc_defs.vh"

module dbc_delay_sel (
   input  wire       clock,       // System clock
   input  wire       reset,       // Synchronous reset, active high
   input  wire [3:0] target_code, // Fixed target code, zero selects automatic
   input  wire [1:0] slew_code,   // Driver slew rate setting
   output reg  [4:0] delay_steps, // Effective delay in 0.2 us steps
   output reg        delay_auto   // High while automatic selection applies
);

   // ========================================================================
   // Automatic table: slower edges need a longer target
   // ========================================================================
   function [4:0] dbc_auto_steps;
      input [1:0] code;
      begin
         case (code)
            2'h0: dbc_auto_steps = `DBC_AUTO_S0;   // Slowest edge rate
            2'h1: dbc_auto_steps = `DBC_AUTO_S1;
            2'h2: dbc_auto_steps = `DBC_AUTO_S2;
            default: dbc_auto_steps = `DBC_AUTO_S3;
         endcase
      end
   endfunction

   // ========================================================================
   // Registered selection
   // ========================================================================
   always @(posedge clock) begin
      if (reset) begin
         delay_steps <= 5'h00;
         delay_auto  <= 1'b1;
      end else if (target_code == 4'h0) begin
         delay_steps <= dbc_auto_steps(slew_code);
         delay_auto  <= 1'b1;
      end else begin
         // Code n means 0.4 us plus (n-1) steps of 0.2 us
         delay_steps <= {1'b0, target_code} + `DBC_DLY_BASE_STEPS;
         delay_auto  <= 1'b0;
      end
   end

endmodule // dbc_delay_sel

// file: hw/dbc_regs.v
// Purpose: Driver and buck configuration register bank on Avalon-MM
// Assumes: Single clock; software is the only party on the register side
// Notes:   Reads answer one cycle after the request with waitrequest low
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "dbc_defs.vh"

module dbc_regs (
   input  wire        clock,                 // System clock, 10 MHz
   input  wire        reset,                 // Synchronous reset, active high
   input  wire [9:0]  avs_address,           // Byte address
   input  wire        avs_read,              // Read request
   input  wire        avs_write,             // Write request
   input  wire [31:0] avs_writedata,         // Write data
   input  wire [3:0]  avs_byteenable,        // Byte lanes of a write
   output reg  [31:0] avs_readdata,          // Read data
   output wire        avs_waitrequest,       // Stall until answer is ready
   output wire [1:0]  avs_response,          // 00 okay, 11 unmapped
   input  wire [1:0]  driver_slew_code,      // Slew setting of the gate driver
   output reg         delay_comp_on,         // Delay compensation enabled
   output wire [4:0]  target_delay_steps,    // Effective delay, 0.2 us steps
   output wire        target_delay_auto,     // Automatic delay in use
   output reg         regulator_edge_rate,   // 1 selects slow switch edges
   output reg         regulator_seq_off,     // 1 means sequencing disabled
   output reg         regulator_current_cap, // 1 selects low current limit
   output reg  [1:0]  regulator_vsel,        // Output voltage code
   output reg         regulator_off,         // 1 turns the regulator off
   output reg  [31:0] algo_config_one_q,     // Algorithm word one contents
   output reg  [31:0] algo_config_two_q      // Algorithm word two contents
);

   // ========================================================================
   // Declarations
   // ========================================================================
   reg  [31:0] algo_config_one;        // Algorithm word one
   reg  [31:0] algo_config_two;        // Algorithm word two
   reg  [31:0] driver_and_buck_config; // Mixed-access configuration word
   reg         rd_done;                // Read answer phase
   reg         rd_err;                 // Unmapped read flag
   reg  [31:0] next_cfg;               // Next configuration word
   wire [7:0]  word_idx;               // Word index from byte address
   wire        hit_one;                // Address decodes
   wire        hit_two;
   wire        hit_cfg;
   wire        hit_stat;
   wire        mapped;                 // Any register hit
   wire        wr_ok;                  // Write accepted this cycle
   wire [31:0] bmask;                  // Byte-enable bit mask
   wire [31:0] status_word;            // Read-only live state

   assign word_idx = avs_address[9:2];
   assign hit_one  = (word_idx == `DBC_IDX_ALGO_ONE);
   assign hit_two  = (word_idx == `DBC_IDX_ALGO_TWO);
   assign hit_cfg  = (word_idx == `DBC_IDX_DRV_BUCK);
   assign hit_stat = (word_idx == `DBC_IDX_STATUS);
   assign mapped   = hit_one | hit_two | hit_cfg | hit_stat;
   assign bmask    = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   // Writes finish in their first cycle; reads wait one cycle for data
   assign avs_waitrequest = avs_read & ~rd_done;
   assign wr_ok           = avs_write;
   assign avs_response    = rd_err ? 2'h3 : 2'h0;
   assign status_word     = {26'h0000000, target_delay_auto, target_delay_steps};

   // ========================================================================
   // Merge helper for byte-enabled writes
   // ========================================================================
   function [31:0] dbc_merge;
      input [31:0] old_val;
      input [31:0] new_val;
      input [31:0] mask;
      begin
         dbc_merge = (old_val & ~mask) | (new_val & mask);
      end
   endfunction

   // ========================================================================
   // Next configuration word; bit 24 is write-one-to-clear
   // ========================================================================
   always @* begin
      next_cfg = driver_and_buck_config;
      if (wr_ok && hit_cfg) begin
         // Plain read-write fields, parity and reserved bits included
         next_cfg = dbc_merge(driver_and_buck_config, avs_writedata, bmask);
         // Writing one clears, writing zero keeps the old value
         next_cfg[`DBC_BIT_SEQ_OFF] = driver_and_buck_config[`DBC_BIT_SEQ_OFF]
            & ~(avs_writedata[`DBC_BIT_SEQ_OFF] & avs_byteenable[3]);
      end
   end

   // ========================================================================
   // Register storage
   // ========================================================================
   always @(posedge clock) begin
      if (reset) begin
         // Word one has no defined reset; zero keeps simulation clean
         algo_config_one        <= `DBC_RST_ALGO_ONE;
         algo_config_two        <= `DBC_RST_ALGO_TWO;
         driver_and_buck_config <= `DBC_RST_DRV_BUCK;
      end else begin
         // Software keeps to listed words; others are ignored
         if (wr_ok && hit_one) begin
            algo_config_one <= dbc_merge(algo_config_one, avs_writedata, bmask);
         end
         if (wr_ok && hit_two) begin
            algo_config_two <= dbc_merge(algo_config_two, avs_writedata, bmask);
         end
         driver_and_buck_config <= next_cfg;
      end
   end

   // ========================================================================
   // Field outputs registered from the configuration word; algorithm word copies registered
   // ========================================================================
   always @(posedge clock) begin
      if (reset) begin
         delay_comp_on         <= 1'b0;
         regulator_edge_rate   <= 1'b0;
         regulator_seq_off     <= 1'b1;
         regulator_current_cap <= 1'b0;
         regulator_vsel        <= 2'h1;
         regulator_off         <= 1'b0;
         algo_config_one_q     <= `DBC_RST_ALGO_ONE;
         algo_config_two_q     <= `DBC_RST_ALGO_TWO;
      end else begin
         delay_comp_on         <= driver_and_buck_config[`DBC_BIT_COMP_EN];
         regulator_edge_rate   <= driver_and_buck_config[`DBC_BIT_EDGE_RATE];
         regulator_seq_off     <= driver_and_buck_config[`DBC_BIT_SEQ_OFF];
         regulator_current_cap <= driver_and_buck_config[`DBC_BIT_CUR_CAP];
         regulator_vsel        <= driver_and_buck_config[`DBC_VSEL_HI:`DBC_VSEL_LO];
         regulator_off         <= driver_and_buck_config[`DBC_BIT_REG_OFF];
         algo_config_one_q     <= algo_config_one;
         algo_config_two_q     <= algo_config_two;
      end
   end

   // ========================================================================
   // Read path: data registered, presented with waitrequest low
   // ========================================================================
   always @(posedge clock) begin
      if (reset) begin
         rd_done      <= 1'b0;
         rd_err       <= 1'b0;
         avs_readdata <= 32'h00000000;
      end else if (avs_read && !rd_done) begin
         rd_done <= 1'b1;
         rd_err  <= ~mapped;
         if (hit_one) begin
            avs_readdata <= algo_config_one;
         end else if (hit_two) begin
            avs_readdata <= algo_config_two;
         end else if (hit_cfg) begin
            avs_readdata <= driver_and_buck_config;
         end else if (hit_stat) begin
            avs_readdata <= status_word;
         end else begin
            // Unmapped reads return zero with an error response
            avs_readdata <= 32'h00000000;
         end
      end else begin
         rd_done <= 1'b0;
         rd_err  <= 1'b0;
      end
   end

   // ========================================================================
   // Target delay resolution
   // ========================================================================
   dbc_delay_sel u_delay (
      .clock       (clock),
      .reset       (reset),
      .target_code (driver_and_buck_config[`DBC_TDLY_HI:`DBC_TDLY_LO]),
      .slew_code   (driver_slew_code),
      .delay_steps (target_delay_steps),
      .delay_auto  (target_delay_auto)
   );

endmodule // dbc_regs

// file: tb/dbc_regs_props.sv
// Purpose: Port assertions for the configuration register bank
// Assumes: One clock; synchronous active-high reset
// Notes:   Field and delay outputs both show a write two edges after it
`timescale 1ns/10ps
module dbc_regs_props (
   input wire        clock,
   input wire        reset,
   input wire [9:0]  avs_address,
   input wire        avs_read,
   input wire        avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0]  avs_byteenable,
   input wire [31:0] avs_readdata,
   input wire        avs_waitrequest,
   input wire [1:0]  avs_response,
   input wire [1:0]  driver_slew_code,
   input wire        delay_comp_on,
   input wire [4:0]  target_delay_steps,
   input wire        target_delay_auto,
   input wire        regulator_edge_rate,
   input wire        regulator_seq_off,
   input wire        regulator_current_cap,
   input wire [1:0]  regulator_vsel,
   input wire        regulator_off,
   input wire [31:0] algo_config_one_q,
   input wire [31:0] algo_config_two_q
);
   // Config word write, top lane and next lane
   wire hi_wr = avs_write && avs_address == 10'h2B8 && avs_byteenable[3];
   wire lo_wr = avs_write && avs_address == 10'h2B8 && avs_byteenable[2];
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // ==========================================================================
   // Assertions
   // ==========================================================================
   a_read_answers: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
      else $error("read not answered in one cycle");
   a_seq_cleared: assert property (hi_wr && avs_writedata[24] |-> ##2 !regulator_seq_off)
      else $error("sequencing flag not cleared");
   a_seq_no_set: assert property ($rose(regulator_seq_off) |-> $past(reset, 2))
      else $error("sequencing flag set without reset");
   a_comp_follows: assert property (hi_wr |-> ##2 delay_comp_on == $past(avs_writedata[30], 2))
      else $error("compensation enable wrong");
   a_edge_follows: assert property (hi_wr |-> ##2 regulator_edge_rate == $past(avs_writedata[25], 2))
      else $error("edge rate wrong");
   a_buck_fields: assert property (lo_wr |-> ##2
      {regulator_current_cap, regulator_vsel, regulator_off} == $past(avs_writedata[23:20], 2))
      else $error("buck fields wrong");
   a_fixed_delay: assert property (hi_wr && avs_writedata[29:26] != 4'h0 |-> ##2
      !target_delay_auto && target_delay_steps == $past(avs_writedata[29:26], 2) + 5'h01)
      else $error("fixed delay wrong");
   a_auto_table: assert property (target_delay_auto && $stable(driver_slew_code)[*3] |->
      target_delay_steps == (driver_slew_code == 2'h0 ? 5'h10 : driver_slew_code == 2'h1 ?
      5'h0C : driver_slew_code == 2'h2 ? 5'h06 : 5'h04))
      else $error("automatic delay wrong");
   // Main scenarios reached
   c_read: cover property (avs_read && !avs_waitrequest);
   c_clear: cover property (hi_wr && avs_writedata[24]);
   c_unmapped: cover property (avs_response == 2'h3);
endmodule // dbc_regs_props

bind dbc_regs dbc_regs_props i_dbc_regs_props (.*);

// file: tb/test_driver_buck_config_regs.sv
// Purpose: Self-checking bench for the configuration register bank
// Assumes: Avalon-MM master holds each request until waitrequest is low
// Notes:   Expected values come from the reset and delay code tables and from the data written
`timescale 1ns/10ps
`include "dbc_defs.vh"
module test_driver_buck_config_regs;
   logic        clock = 0, reset = 1, avs_read = 0, avs_write = 0, avs_waitrequest;
   logic [9:0]  avs_address = 0;
   logic [31:0] avs_writedata = 0, avs_readdata, algo_config_one_q, algo_config_two_q, rd;
   logic [3:0]  avs_byteenable = 0;
   logic [1:0]  avs_response, regulator_vsel, rs, driver_slew_code = 0;
   logic [4:0]  target_delay_steps;
   logic        delay_comp_on, target_delay_auto, regulator_edge_rate, regulator_seq_off;
   logic        regulator_current_cap, regulator_off;
   int          mismatches = 0, n_compared = 0;
   dbc_regs i_dbc_regs (.*);
   // 10 MHz clock
   always #50 clock = ~clock;
   // ==========================================================================
   // Shared tasks
   // ==========================================================================
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One bus cycle; ends one edge after release so the next never collides
   task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d,
                       input logic [3:0] be);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      if (wr) avs_write <= 1'b1;
      else avs_read <= 1'b1;
      @(posedge clock);
      while (avs_waitrequest !== 1'b0 && n < 20) begin
         n++;
         @(posedge clock);
      end
      if (n == 20) mismatches++;
      rd = avs_readdata;
      rs = avs_response;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rchk(input logic [9:0] a, input logic [31:0] exp, input string what);
      xfer(1'b0, a, 32'h0, 4'h0);
      chk(what, exp, rd);
   endtask
   // Write the config word, then let field and delay outputs settle
   task automatic wcfg(input logic [31:0] d);
      xfer(1'b1, 10'h2B8, d, 4'hF);
      repeat (3) @(posedge clock);
   endtask
   // Field outputs packed: comp, auto, steps, edge, seq, cap, vsel, off
   task automatic fld(input logic [12:0] exp);
      chk("fields", {19'h0, exp}, {19'h0, delay_comp_on, target_delay_auto, target_delay_steps,
          regulator_edge_rate, regulator_seq_off, regulator_current_cap, regulator_vsel,
          regulator_off});
   endtask
   // ==========================================================================
   // Scenarios
   // ==========================================================================
   task automatic t_reset;
      rchk(10'h2B8, `DBC_RST_DRV_BUCK, "config reset");
      chk("config resp", 32'h0, {30'h0, rs});
      rchk(10'h288, 32'h00000000, "algo two reset");
      chk("algo two out reset", 32'h0, algo_config_two_q);
      rchk(10'h280, `DBC_RST_ALGO_ONE, "algo one reset");
      fld({1'b0, 1'b1, 5'h10, 1'b0, 1'b1, 1'b0, 2'b01, 1'b0});
   endtask
   task automatic t_all_fields;
      wcfg(32'h00200000);
      rchk(10'h2B8, 32'h01200000, "zero keeps flag");
      wcfg(32'hFFFFFFFF);
      rchk(10'h2B8, 32'hFEFFFFFF, "all ones");
      fld({1'b1, 1'b0, 5'h10, 1'b1, 1'b0, 1'b1, 2'b11, 1'b1});
      wcfg(32'h00000000);
      fld({1'b0, 1'b1, 5'h10, 1'b0, 1'b0, 1'b0, 2'b00, 1'b0});
   endtask
   task automatic t_delay;
      logic [4:0] auto_tab [4];
      auto_tab = '{`DBC_AUTO_S0, `DBC_AUTO_S1, `DBC_AUTO_S2, `DBC_AUTO_S3};
      for (int c = 1; c < 16; c++) begin
         wcfg({2'b00, c[3:0], 26'h0});
         chk("fixed steps", {27'h0, c[4:0] + 5'h01}, {27'h0, target_delay_steps});
      end
      wcfg(32'h0);
      for (int s = 0; s < 4; s++) begin
         driver_slew_code <= s[1:0];
         repeat (4) @(posedge clock);
         chk("auto steps", {26'h0, 1'b1, auto_tab[s]},
             {26'h0, target_delay_auto, target_delay_steps});
      end
   endtask
   task automatic t_vsel;
      for (int v = 0; v < 4; v++) begin
         wcfg({9'h0, v[1:0], 21'h0});
         chk("vsel", v, {30'h0, regulator_vsel});
      end
   endtask
   task automatic t_algo_unmapped;
      xfer(1'b1, 10'h280, 32'h12345678, 4'hF);
      xfer(1'b1, 10'h288, 32'h9ABCDEF0, 4'h3);
      xfer(1'b1, 10'h3FC, 32'hFFFFFFFF, 4'hF);
      rchk(10'h280, 32'h12345678, "algo one");
      rchk(10'h288, 32'h0000DEF0, "algo two lanes");
      chk("algo one out", 32'h12345678, algo_config_one_q);
      chk("algo two out", 32'h0000DEF0, algo_config_two_q);
      rchk(10'h3FC, 32'h0, "unmapped data");
      chk("unmapped resp", 32'h3, {30'h0, rs});
      // Status word: last config left automatic delay with slew code 3
      rchk(10'h2C0, {26'h0, 1'b1, `DBC_AUTO_S3}, "status word");
   endtask
   // Second reset in mid-run restores the reset word
   task automatic t_reset_again;
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      rchk(10'h2B8, `DBC_RST_DRV_BUCK, "config after reset");
      fld({1'b0, 1'b1, `DBC_AUTO_S3, 1'b0, 1'b1, 1'b0, 2'b01, 1'b0});
   endtask
   task automatic summarize;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Watchdog: 3000 cycles; the run needs well under that
   initial begin
      #(3000 * 100);
      mismatches++;
      summarize;
   end
   initial begin
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      t_reset;
      t_all_fields;
      t_delay;
      t_vsel;
      t_algo_unmapped;
      t_reset_again;
      summarize;
   end
endmodule // test_driver_buck_config_regs
